/* File: strap_cfg_pkg.sv */
// package: register map, field layout and reset values of the port 0 strap configuration block
package strap_cfg_pkg;

	// register byte offsets
	localparam logic [7:0] STRAP_STATUS_OFFSET = 8'h00;
	localparam logic [7:0] FLOW_CTRL_OFFSET    = 8'h04;
	localparam logic [7:0] PHY_SPECIAL_OFFSET  = 8'h08;
	localparam logic [7:0] PHY_ADDR_OFFSET     = 8'h0c;
	localparam logic [7:0] LINK_CTRL_OFFSET    = 8'h10;

	// flow control register field positions
	localparam int BP_EN_BIT       = 0;
	localparam int TX_PAUSE_BIT    = 1;
	localparam int RX_PAUSE_BIT    = 2;
	localparam int MANUAL_FLOW_BIT = 3;

	// special control field position
	localparam int HEARTBEAT_OFF_BIT = 0;

	// link control field positions
	localparam int AN_FAIL_BIT = 0;
	localparam int AN_PAUSE_BIT = 1;

	// reset values
	localparam logic [3:0] FLOW_CTRL_RESET = 4'h0;
	localparam logic       HEARTBEAT_RESET = 1'b0;
	localparam logic [1:0] LINK_CTRL_RESET = 2'h0;
	localparam logic [7:0] STRAP_RESET     = 8'h00;

	// settle count after reset release before the load; the two-flop pin pipeline already holds valid strap levels after 2 cycles
	localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h3;

	// base management address per strap value
	localparam logic [4:0] PHY_ADDR_BASE_0 = 5'h00;
	localparam logic [4:0] PHY_ADDR_BASE_1 = 5'h01;

	// latched hard and soft strap set
	typedef struct packed {
		logic duplex_pin;
		logic duplex_polarity;
		logic backpressure;
		logic fd_flow;
		logic manual_flow;
		logic heartbeat_off;
		logic phy_addr_sel;
		logic speed;
		logic phy_mode;
	} strap_set_t;

	// resolved port 0 configuration
	typedef struct packed {
		logic       full_duplex;
		logic       speed_100;
		logic       backpressure;
		logic       tx_pause;
		logic       rx_pause;
		logic       heartbeat_off;
		logic [4:0] vphy_addr;
		logic [4:0] port1_addr;
		logic [4:0] port2_addr;
	} port0_cfg_t;

endpackage

/* File: port0_strap_config_latch.sv */
// port 0 strap latch, strap-derived register defaults and ahb-lite register slave
module port0_strap_config_latch (
	// clock and reset
	input  wire logic                     i_clk,
	input  wire logic                     i_resetn,
	// strap pins
	input  wire strap_cfg_pkg::strap_set_t i_strap_pins,
	// ahb-lite slave
	input  wire logic                     i_hsel,
	input  wire logic [31:0]              i_haddr,
	input  wire logic [1:0]               i_htrans,
	input  wire logic                     i_hwrite,
	input  wire logic [2:0]               i_hsize,
	input  wire logic [31:0]              i_hwdata,
	input  wire logic                     i_hready,
	output logic      [31:0]              o_hrdata,
	output logic                          o_hreadyout,
	output logic                          o_hresp,
	// resolved configuration
	output strap_cfg_pkg::port0_cfg_t     o_port0_cfg,
	output logic                          o_strap_valid
);
	import strap_cfg_pkg::*;

	typedef enum logic [2:0] {
		ST_SETTLE = 3'b001,
		ST_LOAD   = 3'b010,
		ST_RUN    = 3'b100
	} load_state_t;

	load_state_t state_reg;
	load_state_t state_next;
	strap_set_t  sync1_reg;
	strap_set_t  sync2_reg;
	strap_set_t  strap_reg;
	logic [1:0]  settle_reg;
	logic [3:0]  flow_reg;
	logic        heartbeat_reg;
	logic [1:0]  link_reg;
	logic        wr_pend_reg;
	logic [7:0]  wr_addr_reg;
	logic [31:0] rdata_reg;
	port0_cfg_t  cfg_reg;
	logic        valid_reg;

	// decode
	wire         bus_access   = i_hsel & i_hready & i_htrans[1];
	wire         rd_access    = bus_access & ~i_hwrite;
	wire         wr_access    = bus_access & i_hwrite;
	wire         wr_flow      = wr_pend_reg & (wr_addr_reg == FLOW_CTRL_OFFSET);
	wire         wr_special   = wr_pend_reg & (wr_addr_reg == PHY_SPECIAL_OFFSET);
	wire         wr_link      = wr_pend_reg & (wr_addr_reg == LINK_CTRL_OFFSET);
	wire         loading      = (state_reg == ST_LOAD);
	wire         settling     = (state_reg == ST_SETTLE);
	wire         mac_mode     = ~strap_reg.phy_mode;

	// read select, one per mapped word; unmapped offsets fall through to zero
	wire [7:0]   rd_offset    = i_haddr[7:0];
	wire         sel_status   = (rd_offset == STRAP_STATUS_OFFSET);
	wire         sel_flow     = (rd_offset == FLOW_CTRL_OFFSET);
	wire         sel_special  = (rd_offset == PHY_SPECIAL_OFFSET);
	wire         sel_addr     = (rd_offset == PHY_ADDR_OFFSET);
	wire         sel_link     = (rd_offset == LINK_CTRL_OFFSET);
	wire [31:0]  status_word  = {23'h0, strap_reg};
	wire [31:0]  flow_word    = {28'h0, flow_reg};
	wire [31:0]  special_word = {31'h0, heartbeat_reg};
	wire [31:0]  addr_word    = {17'h0, cfg_reg.port2_addr, cfg_reg.port1_addr, cfg_reg.vphy_addr};
	wire [31:0]  link_word    = {30'h0, link_reg};
	wire [31:0]  rd_mux       = ({32{sel_status}} & status_word) |
	                            ({32{sel_flow}} & flow_word) |
	                            ({32{sel_special}} & special_word) |
	                            ({32{sel_addr}} & addr_word) |
	                            ({32{sel_link}} & link_word);

	// resolved configuration terms
	wire         full_duplex  = (strap_reg.duplex_pin == strap_reg.duplex_polarity);
	// in mac mode the manual flow strap is dropped and pause bits rule alone
	wire         manual_eff   = flow_reg[MANUAL_FLOW_BIT] | mac_mode;
	wire         auto_pause   = link_reg[AN_PAUSE_BIT];
	wire         tx_pause     = manual_eff ? flow_reg[TX_PAUSE_BIT] : auto_pause;
	wire         rx_pause     = manual_eff ? flow_reg[RX_PAUSE_BIT] : auto_pause;
	// autoneg failure only means anything with the emulated phy present
	wire         strap_speed  = link_reg[AN_FAIL_BIT] | mac_mode;
	wire         speed_100    = strap_speed ? strap_reg.speed : 1'b1;
	wire [4:0]   addr_base    = strap_reg.phy_addr_sel ? PHY_ADDR_BASE_1 : PHY_ADDR_BASE_0;
	wire [4:0]   port1_base   = addr_base + 5'h01;
	wire [4:0]   port2_base   = addr_base + 5'h02;

	always_comb begin
		case (state_reg)
			ST_SETTLE: state_next = (settle_reg == STRAP_SETTLE_CYCLES) ? ST_LOAD : ST_SETTLE;
			ST_LOAD:   state_next = ST_RUN;
			ST_RUN:    state_next = ST_RUN;
			default:   state_next = ST_SETTLE;
		endcase
	end

	// two flops on every strap pin; only the second one is read
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			sync1_reg <= STRAP_RESET;
			sync2_reg <= STRAP_RESET;
		end else begin
			sync1_reg <= i_strap_pins;
			sync2_reg <= sync1_reg;
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_reg  <= ST_SETTLE;
			settle_reg <= 2'h0;
		end else begin
			state_reg <= state_next;
			if (settling) begin
				settle_reg <= settle_reg + 2'h1;
			end
		end
	end

	// i_resetn is the combined power-on and external pin reset; no other reset reaches
	// the strap latch, so soft resets cannot re-sample the pins
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			strap_reg <= STRAP_RESET;
		end else if (loading) begin
			strap_reg <= sync2_reg;
		end
	end

	// register defaults are loaded from straps once; bus writes change them afterwards
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			flow_reg <= FLOW_CTRL_RESET;
		end else if (loading) begin
			flow_reg[BP_EN_BIT]       <= sync2_reg.backpressure;
			flow_reg[TX_PAUSE_BIT]    <= sync2_reg.fd_flow;
			flow_reg[RX_PAUSE_BIT]    <= sync2_reg.fd_flow;
			flow_reg[MANUAL_FLOW_BIT] <= sync2_reg.manual_flow | ~sync2_reg.phy_mode;
		end else if (wr_flow) begin
			flow_reg <= i_hwdata[3:0];
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			heartbeat_reg <= HEARTBEAT_RESET;
		end else if (loading) begin
			heartbeat_reg <= sync2_reg.heartbeat_off;
		end else if (wr_special) begin
			heartbeat_reg <= i_hwdata[HEARTBEAT_OFF_BIT];
		end
	end

	// software reports the emulated negotiation outcome here; no strap feeds it
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			link_reg <= LINK_CTRL_RESET;
		end else if (wr_link) begin
			link_reg <= i_hwdata[1:0];
		end
	end

	// bus slave: zero wait states, always okay; unmapped reads return zero
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
		end else begin
			wr_pend_reg <= wr_access;
			wr_addr_reg <= i_haddr[7:0];
		end
	end

	// read data is captured in the address phase, so a read right behind a write
	// to the same word returns the old value
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rdata_reg <= 32'h0;
		end else if (rd_access) begin
			rdata_reg <= rd_mux;
		end
	end

	// valid rises with the load and only a new reset takes it down
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			valid_reg <= 1'b0;
		end else if (loading) begin
			valid_reg <= 1'b1;
		end
	end

	// half duplex uses backpressure and full duplex pause frames, never both at once
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			cfg_reg <= '0;
		end else begin
			cfg_reg.full_duplex   <= full_duplex;
			cfg_reg.speed_100     <= speed_100;
			cfg_reg.backpressure  <= flow_reg[BP_EN_BIT] & ~full_duplex;
			cfg_reg.tx_pause      <= tx_pause & full_duplex;
			cfg_reg.rx_pause      <= rx_pause & full_duplex;
			cfg_reg.heartbeat_off <= heartbeat_reg | mac_mode;
			cfg_reg.vphy_addr     <= addr_base;
			cfg_reg.port1_addr    <= port1_base;
			cfg_reg.port2_addr    <= port2_base;
		end
	end

	assign o_hrdata      = rdata_reg;
	assign o_hreadyout   = 1'b1;
	assign o_hresp       = 1'b0;
	assign o_port0_cfg   = cfg_reg;
	assign o_strap_valid = valid_reg;

	wire unused_ok = &{1'b0, i_hsize, i_haddr[31:8]};
endmodule

/* File: strap_cfg_checker_properties.sv */
// checker: port 0 strap latch timing, hold and derived configuration relations
module strap_cfg_checker (
	// clock and reset
	input wire logic                      i_clk,
	input wire logic                      i_resetn,
	// observed outputs
	input wire strap_cfg_pkg::port0_cfg_t o_port0_cfg,
	input wire logic                      o_strap_valid
);
	import strap_cfg_pkg::*;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	// a latch slower than the settle window would leave defaults unloaded
	settle_latch_a: assert property (
		$rose(i_resetn) |-> !o_strap_valid[*4] ##[1:4] o_strap_valid)
		else $error("strap latch timing wrong");
	valid_hold_a: assert property (o_strap_valid |=> o_strap_valid)
		else $error("strap valid dropped");
	duplex_hold_a: assert property (
		$past(o_strap_valid, 2) |-> $stable(o_port0_cfg.full_duplex))
		else $error("duplex changed after latch");
	addr_hold_a: assert property (
		$past(o_strap_valid, 2) |-> $stable(o_port0_cfg.vphy_addr))
		else $error("address changed after latch");
	addr_pair_a: assert property (
		$past(o_strap_valid) |-> o_port0_cfg.port1_addr == o_port0_cfg.vphy_addr + 5'h01
		&& o_port0_cfg.port2_addr == o_port0_cfg.vphy_addr + 5'h02)
		else $error("port addresses not consecutive");
	addr_base_a: assert property (
		$past(o_strap_valid) |-> o_port0_cfg.vphy_addr inside {5'h00, 5'h01})
		else $error("base address out of range");
	pause_gate_a: assert property (
		!o_port0_cfg.full_duplex |-> !o_port0_cfg.tx_pause && !o_port0_cfg.rx_pause)
		else $error("pause active in half duplex");
	bp_gate_a: assert property (o_port0_cfg.full_duplex |-> !o_port0_cfg.backpressure)
		else $error("backpressure active in full duplex");
	cover property ($rose(o_strap_valid));
	cover property (o_port0_cfg.tx_pause);
	cover property (o_port0_cfg.backpressure);
endmodule
bind port0_strap_config_latch strap_cfg_checker u_strap_cfg_checker (
	.i_clk(i_clk), .i_resetn(i_resetn),
	.o_port0_cfg(o_port0_cfg), .o_strap_valid(o_strap_valid));

/* File: strap_board.sv */
// board strap model: each strap is its own pull resistor, a steady level on a dedicated pin
module strap_board (
	// chosen board levels
	input  wire strap_cfg_pkg::strap_set_t i_level,
	// pins seen by the device
	output strap_cfg_pkg::strap_set_t      o_pins
);
	timeunit 1ns;
	timeprecision 1ps;
	assign o_pins = i_level;
endmodule

/* File: tb_top.sv */
// testbench: strap latching, register defaults and derived port 0 configuration
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import strap_cfg_pkg::*;
	logic        clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp, valid;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
	strap_set_t  lvl = 9'h000, pins;
	port0_cfg_t  cfg;
	int          n_fail = 0, checked = 0;
	strap_set_t  pats [4] = '{9'h1b1, 9'h1cf, 9'h068, 9'h156};
	always #12.5 clk = ~clk;
	strap_board u_strap_board (.i_level(lvl), .o_pins(pins));
	port0_strap_config_latch u_port0_strap_config_latch (.i_clk(clk), .i_resetn(rstn),
		.i_strap_pins(pins), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
		.i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hreadyout), .o_hrdata(hrdata),
		.o_hreadyout(hreadyout), .o_hresp(hresp), .o_port0_cfg(cfg), .o_strap_valid(valid));
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			n_fail++;
			$display("BAD %0t saw %h expected %h", $time, s, e);
		end
	endtask
	task automatic wrdy();
		int i;
		for (i = 0; i < 20 && hreadyout !== 1'b1; i++) @(posedge clk);
		if (i == 20) begin
			n_fail++;
			wrap_up();
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		@(posedge clk);
		wrdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk);
		wrdy();
		r = hrdata;
	endtask
	task automatic run(input strap_set_t p);
		logic       fdx, man;
		logic [4:0] a;
		fdx = p.duplex_pin == p.duplex_polarity;
		man = p.manual_flow | ~p.phy_mode;
		a = {4'h0, p.phy_addr_sel};
		lvl <= p;
		rstn <= 1'b0;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
		chk({hresp, valid}, 32'h0);
		repeat (8) @(posedge clk);
		bus(1'b0, STRAP_STATUS_OFFSET, 32'h0);
		chk(r, {23'h0, p});
		bus(1'b0, FLOW_CTRL_OFFSET, 32'h0);
		chk(r[3:0], {man, p.fd_flow, p.fd_flow, p.backpressure});
		bus(1'b0, PHY_SPECIAL_OFFSET, 32'h0);
		chk(r[0], p.heartbeat_off);
		bus(1'b0, PHY_ADDR_OFFSET, 32'h0);
		chk(r[14:0], {a + 5'h02, a + 5'h01, a});
		chk(cfg.full_duplex, fdx);
		chk(cfg.backpressure, p.backpressure & ~fdx);
		chk({cfg.tx_pause, cfg.rx_pause}, {2{fdx & man & p.fd_flow}});
		chk(cfg.heartbeat_off, {p.heartbeat_off | ~p.phy_mode});
		chk(cfg.speed_100, p.speed | p.phy_mode);
		chk({hresp, valid}, 32'h1);
		// host reports a failed negotiation with pause granted
		bus(1'b1, LINK_CTRL_OFFSET, 32'h3);
		repeat (3) @(posedge clk);
		chk(cfg.speed_100, p.speed);
		chk({cfg.tx_pause, cfg.rx_pause}, {2{fdx & (man ? p.fd_flow : 1'b1)}});
		bus(1'b1, PHY_SPECIAL_OFFSET, {31'h0, ~p.heartbeat_off});
		bus(1'b0, PHY_SPECIAL_OFFSET, 32'h0);
		chk(r[0], {~p.heartbeat_off});
		chk(cfg.heartbeat_off, {~p.heartbeat_off | ~p.phy_mode});
		lvl <= ~p;
		bus(1'b1, STRAP_STATUS_OFFSET, 32'h1ff);
		repeat (4) @(posedge clk);
		bus(1'b0, STRAP_STATUS_OFFSET, 32'h0);
		chk(r, {23'h0, p});
		chk(cfg.full_duplex, fdx);
		bus(1'b0, 8'h40, 32'h0);
		chk(r, 32'h0);
		$display("test %h done", p);
	endtask
	initial begin
		@(posedge clk);
		foreach (pats[i]) run(pats[i]);
		wrap_up();
	end
endmodule
